// ### rtl/cis_pkg.sv
// Purpose: Constants and types for the charger control and interrupt register bank
// Assumes: Avalon-MM slave, 32-bit data, register at byte address four times its index
// Notes:   Only byte lane 0 carries register data
package cis_pkg;

   // Register indices; byte address is index times four
   localparam logic [7:0] IDX_RESERVED_A = 8'h70;
   localparam logic [7:0] IDX_CONFIG     = 8'h71;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h78;
   localparam logic [7:0] IDX_IRQ_ENABLE = 8'h79;
   localparam logic [7:0] IDX_STATE      = 8'h7A;

   // Configuration fields
   localparam int CFG_SUSPEND_BIT = 7;
   localparam int CFG_TOTAL_LSB   = 4;
   localparam int CFG_PRECOND_LSB = 2;
   localparam int CFG_OVP_LSB     = 0;

   // Status register: group flags high nibble, live levels low nibble
   localparam int STS_GROUP_LSB = 4;
   localparam int STS_TIMER_BIT = 3;
   localparam int STS_TEMP_BIT  = 2;
   localparam int STS_INPUT_BIT = 1;
   localparam int STS_EOC_BIT   = 0;

   // Group index inside the four-bit group vectors
   localparam int GRP_TIMER = 3;
   localparam int GRP_TEMP  = 2;
   localparam int GRP_INPUT = 1;
   localparam int GRP_EOC   = 0;

   // Enable register bits
   localparam int EN_TOTAL     = 7;
   localparam int EN_TEMP_IN   = 6;
   localparam int EN_CONNECT   = 5;
   localparam int EN_DONE_IN   = 4;
   localparam int EN_PRECHARGE = 3;
   localparam int EN_TEMP_OUT  = 2;
   localparam int EN_DISCONN   = 1;
   localparam int EN_DONE_OUT  = 0;

   // State register fields
   localparam int ST_PHASE_LSB = 4;
   localparam int ST_AC_BIT    = 1;

   // Values after reset
   localparam logic [7:0]  RESET_CONFIG = 8'h00;
   localparam logic [7:0]  RESET_ENABLE = 8'h00;
   localparam logic [3:0]  RESET_GROUP  = 4'h0;
   localparam logic [31:0] RESET_RDATA  = 32'h0000_0000;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK  = 2'b10
   } cis_bus_t;

   typedef struct packed {
      cis_bus_t    bus;
      logic        waitReq;
      logic [31:0] rdata;
      logic [7:0]  cfg;
      logic [7:0]  ien;
      logic [3:0]  arm;
      logic [3:0]  pend;
      logic        prevTot;
      logic        prevPre;
      logic        prevTemp;
      logic        prevIn;
      logic        prevEoc;
      logic        irqN;
   } cis_state_t;

endpackage

// ### rtl/cis_charger_regs.sv
// Purpose: Charger configuration, status and interrupt registers on Avalon-MM
// Assumes: Charger status inputs are synchronous levels from the analog charger
// Notes:   Group pending flags clear on a read of the status register
`timescale 1ns/100ps

// Summary of operation
// - Config bit 7 set halts charging; cleared lets charging resume.
// - Config bits 5:4 select total charge safety timeout.
// - Config bits 3:2 select precondition charge safety timeout.
// - Config bits 1:0 select input over-voltage threshold.
// - Total timer expiry interrupts when enable bit 7 and timer flag set.
// - Precondition timer expiry interrupts when enable bit 3 and timer flag set.
// - Temperature entering valid range interrupts with enable bit 6 and flag.
// - Temperature leaving valid range interrupts with enable bit 2 and flag.
// - Input becoming valid (bit 5) or invalid (bit 1) interrupts with flag.
// - Entering end-of-charge interrupts with enable bit 4 and flag.
// - Leaving end-of-charge interrupts with enable bit 0 and flag.
// - Status bit 3 reads 1 when either safety timer timed out.
// - Status bit 2 reads 1 while battery temperature is valid.
// - Status bit 1 reads 1 while a valid charger input exists.
// - Status bit 0 reads 1 while in end-of-charge state.
// - Temperature and end-of-charge events count only with valid input.
// - State register bits 5:4 report present charging phase.
// - State register bit 1 reports AC-detect comparator level.
module cis_charger_regs
   import cis_pkg::*;
#(
   parameter int ADDR_W = 10
)(
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              resetn,
   // Avalon-MM slave
   input  wire logic [ADDR_W-1:0] address,
   input  wire logic              read,
   input  wire logic              write,
   input  wire logic [3:0]        byteenable,
   input  wire logic [31:0]       writedata,
   output logic      [31:0]       readdata,
   output logic                   waitrequest,
   // Charger status levels
   input  wire logic              totalTimeout,
   input  wire logic              precondTimeout,
   input  wire logic              temperatureValid,
   input  wire logic              inputValid,
   input  wire logic              endOfChargeFlag,
   input  wire logic [1:0]        chargingPhase,
   input  wire logic              acDetectLevel,
   // Charger controls
   output logic                   suspendCharging,
   output logic      [1:0]        totalTimeoutSelect,
   output logic      [1:0]        preconditionTimeoutSelect,
   output logic      [1:0]        inputOvervoltageSelect,
   // Interrupt request
   output logic                   irqN
);

   cis_state_t st_r;
   cis_state_t st_nxt;

   logic       req;
   logic       accept;
   logic [7:0] liveStatus;
   logic [7:0] stateWord;
   logic [3:0] grpEvent;

   function automatic logic hitReg(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
      hitReg = (a == ADDR_W'({idx, 2'b00}));
   endfunction

   assign req    = read | write;
   assign accept = req & ~st_r.waitReq;

   assign liveStatus = {st_r.pend, totalTimeout | precondTimeout, temperatureValid,
                        inputValid, endOfChargeFlag};
   assign stateWord  = {2'b00, chargingPhase, 2'b00, acDetectLevel, 1'b0};

   always_comb begin
      grpEvent = 4'h0;
      grpEvent[GRP_TIMER] = (totalTimeout & ~st_r.prevTot & st_r.ien[EN_TOTAL])
                          | (precondTimeout & ~st_r.prevPre & st_r.ien[EN_PRECHARGE]);
      // temperature edges, only with valid input
      grpEvent[GRP_TEMP]  = inputValid &
                            ((temperatureValid & ~st_r.prevTemp & st_r.ien[EN_TEMP_IN])
                           | (~temperatureValid & st_r.prevTemp & st_r.ien[EN_TEMP_OUT]));
      grpEvent[GRP_INPUT] = (inputValid & ~st_r.prevIn & st_r.ien[EN_CONNECT])
                          | (~inputValid & st_r.prevIn & st_r.ien[EN_DISCONN]);
      grpEvent[GRP_EOC]   = inputValid &
                            ((endOfChargeFlag & ~st_r.prevEoc & st_r.ien[EN_DONE_IN])
                           | (~endOfChargeFlag & st_r.prevEoc & st_r.ien[EN_DONE_OUT]));
   end

   always_comb begin
      st_nxt          = st_r;
      st_nxt.prevTot  = totalTimeout;
      st_nxt.prevPre  = precondTimeout;
      st_nxt.prevTemp = temperatureValid;
      st_nxt.prevIn   = inputValid;
      st_nxt.prevEoc  = endOfChargeFlag;

      case (st_r.bus)
         BUS_IDLE: begin
            // Capture read data on the first edge so it stands while waitrequest is low
            if (req) begin
               st_nxt.bus     = BUS_ACK;
               st_nxt.waitReq = 1'b0;
               st_nxt.rdata   = RESET_RDATA;
               if (read) begin
                  if (hitReg(address, IDX_CONFIG)) begin
                     st_nxt.rdata[7:0] = st_r.cfg;
                  end else if (hitReg(address, IDX_IRQ_STATUS)) begin
                     st_nxt.rdata[7:0] = liveStatus;
                  end else if (hitReg(address, IDX_IRQ_ENABLE)) begin
                     st_nxt.rdata[7:0] = st_r.ien;
                  end else if (hitReg(address, IDX_STATE)) begin
                     st_nxt.rdata[7:0] = stateWord;
                  end
               end
            end
         end
         BUS_ACK: begin
            st_nxt.bus     = BUS_IDLE;
            st_nxt.waitReq = 1'b1;
            if (write && byteenable[0]) begin
               // configuration write, reserved bit 6 stored as written
               if (hitReg(address, IDX_CONFIG)) begin
                  st_nxt.cfg = writedata[7:0];
               end
               if (hitReg(address, IDX_IRQ_STATUS)) begin
                  st_nxt.arm = writedata[7:STS_GROUP_LSB];
               end
               if (hitReg(address, IDX_IRQ_ENABLE)) begin
                  st_nxt.ien = writedata[7:0];
               end
            end
            // read clears only the flags that were reported
            if (read && hitReg(address, IDX_IRQ_STATUS)) begin
               st_nxt.pend = st_r.pend & ~st_r.rdata[7:STS_GROUP_LSB];
            end
         end
         default: begin
            st_nxt.bus     = BUS_IDLE;
            st_nxt.waitReq = 1'b1;
         end
      endcase

      st_nxt.pend = st_nxt.pend | (grpEvent & st_r.arm);
      st_nxt.irqN = ~|st_nxt.pend;
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         st_r.bus      <= BUS_IDLE;
         st_r.waitReq  <= 1'b1;
         st_r.rdata    <= RESET_RDATA;
         st_r.cfg      <= RESET_CONFIG;
         st_r.ien      <= RESET_ENABLE;
         st_r.arm      <= RESET_GROUP;
         st_r.pend     <= RESET_GROUP;
         st_r.prevTot  <= 1'b0;
         st_r.prevPre  <= 1'b0;
         st_r.prevTemp <= 1'b0;
         st_r.prevIn   <= 1'b0;
         st_r.prevEoc  <= 1'b0;
         st_r.irqN     <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign readdata                  = st_r.rdata;
   assign waitrequest               = st_r.waitReq;
   assign suspendCharging           = st_r.cfg[CFG_SUSPEND_BIT];
   assign totalTimeoutSelect        = st_r.cfg[CFG_TOTAL_LSB +: 2];
   assign preconditionTimeoutSelect = st_r.cfg[CFG_PRECOND_LSB +: 2];
   assign inputOvervoltageSelect    = st_r.cfg[CFG_OVP_LSB +: 2];
   assign irqN                      = st_r.irqN;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   sequence cfgWrite;
      accept && write && byteenable[0] && hitReg(address, IDX_CONFIG);
   endsequence

   sequence statusRead;
      accept && read && hitReg(address, IDX_IRQ_STATUS);
   endsequence

   sequence enableWrite;
      accept && write && byteenable[0] && hitReg(address, IDX_IRQ_ENABLE);
   endsequence

   sequence armWrite;
      accept && write && byteenable[0] && hitReg(address, IDX_IRQ_STATUS);
   endsequence

   sequence stateRead;
      accept && read && hitReg(address, IDX_STATE);
   endsequence

   // One low cycle, so a held request is never taken twice
   sequence busAnswer;
      !waitrequest ##1 waitrequest;
   endsequence

   // Bus answers one cycle after the request, then rearms
   bus_wait_a: assert property (req && st_r.waitReq |=> !waitrequest ##1 waitrequest)
      else $error("waitrequest did not pulse low for one cycle");

   suspend_write_a: assert property (cfgWrite |=> suspendCharging == $past(writedata[7]))
      else $error("suspend bit did not follow config write");

   select_write_a: assert property (cfgWrite |=>
      {totalTimeoutSelect, preconditionTimeoutSelect, inputOvervoltageSelect}
         == $past(writedata[5:0]))
      else $error("timeout or threshold select did not follow write");

   total_irq_a: assert property (totalTimeout && !st_r.prevTot && st_r.ien[EN_TOTAL]
      && st_r.arm[GRP_TIMER] |=> st_r.pend[GRP_TIMER] && !irqN)
      else $error("total timeout did not raise interrupt");

   // leaving end of charge with valid input
   eoc_leave_a: assert property (!endOfChargeFlag && st_r.prevEoc && inputValid
      && st_r.ien[EN_DONE_OUT] && st_r.arm[GRP_EOC] |=> st_r.pend[GRP_EOC])
      else $error("end-of-charge exit did not set flag");

   // temperature change ignored without valid input
   temp_gate_a: assert property (!inputValid && !st_r.pend[GRP_TEMP] && !statusRead
      |=> !st_r.pend[GRP_TEMP])
      else $error("temperature flag set without valid input");

   timer_read_a: assert property (statusRead |-> readdata[STS_TIMER_BIT] ==
      $past(totalTimeout || precondTimeout))
      else $error("timer status read wrong");

   phase_read_a: assert property (accept && read && hitReg(address, IDX_STATE)
      |-> readdata[5:4] == $past(chargingPhase))
      else $error("charging phase read wrong");

   irq_pend_a: assert property (##1 (irqN == !(|st_r.pend)))
      else $error("interrupt output disagrees with flags");

   arm_gate_a: assert property (!st_r.arm[GRP_INPUT] && !st_r.pend[GRP_INPUT]
      |=> !st_r.pend[GRP_INPUT])
      else $error("unarmed group went pending");

   // Answer lasts one cycle
   answer_once_a: assert property (!waitrequest |-> busAnswer)
      else $error("waitrequest stayed low");

   cfg_hold_a: assert property (!(accept && write && byteenable[0]
      && hitReg(address, IDX_CONFIG)) |=> $stable(st_r.cfg))
      else $error("config changed without a write");

   lane_ignore_a: assert property (accept && write && !byteenable[0]
      |=> $stable(st_r.cfg) && $stable(st_r.ien) && $stable(st_r.arm))
      else $error("write without low byte lane changed a register");

   config_read_a: assert property (accept && read && hitReg(address, IDX_CONFIG)
      |-> readdata[7:0] == $past(st_r.cfg))
      else $error("config read wrong");

   enable_write_a: assert property (enableWrite |=> st_r.ien == $past(writedata[7:0]))
      else $error("interrupt enable did not follow write");

   enable_read_a: assert property (accept && read && hitReg(address, IDX_IRQ_ENABLE)
      |-> readdata[7:0] == $past(st_r.ien))
      else $error("interrupt enable read wrong");

   arm_write_a: assert property (armWrite |=> st_r.arm == $past(writedata[7:4]))
      else $error("group arm mask did not follow write");

   precharge_irq_a: assert property (precondTimeout && !st_r.prevPre
      && st_r.ien[EN_PRECHARGE] && st_r.arm[GRP_TIMER] |=> st_r.pend[GRP_TIMER] && !irqN)
      else $error("precondition timeout did not raise interrupt");

   temp_enter_a: assert property (temperatureValid && !st_r.prevTemp && inputValid
      && st_r.ien[EN_TEMP_IN] && st_r.arm[GRP_TEMP] |=> st_r.pend[GRP_TEMP])
      else $error("temperature entry did not set flag");

   temp_leave_a: assert property (!temperatureValid && st_r.prevTemp && inputValid
      && st_r.ien[EN_TEMP_OUT] && st_r.arm[GRP_TEMP] |=> st_r.pend[GRP_TEMP])
      else $error("temperature exit did not set flag");

   input_conn_a: assert property (inputValid && !st_r.prevIn && st_r.ien[EN_CONNECT]
      && st_r.arm[GRP_INPUT] |=> st_r.pend[GRP_INPUT])
      else $error("input connect did not set flag");

   input_disc_a: assert property (!inputValid && st_r.prevIn && st_r.ien[EN_DISCONN]
      && st_r.arm[GRP_INPUT] |=> st_r.pend[GRP_INPUT])
      else $error("input disconnect did not set flag");

   eoc_enter_a: assert property (endOfChargeFlag && !st_r.prevEoc && inputValid
      && st_r.ien[EN_DONE_IN] && st_r.arm[GRP_EOC] |=> st_r.pend[GRP_EOC])
      else $error("end-of-charge entry did not set flag");

   eoc_gate_a: assert property (!inputValid && !st_r.pend[GRP_EOC]
      |=> !st_r.pend[GRP_EOC])
      else $error("end-of-charge flag set without valid input");

   temp_read_a: assert property (statusRead |->
      readdata[STS_TEMP_BIT] == $past(temperatureValid))
      else $error("temperature status read wrong");

   input_read_a: assert property (statusRead |->
      readdata[STS_INPUT_BIT] == $past(inputValid))
      else $error("input status read wrong");

   eoc_read_a: assert property (statusRead |->
      readdata[STS_EOC_BIT] == $past(endOfChargeFlag))
      else $error("end-of-charge status read wrong");

   group_read_a: assert property (statusRead |-> readdata[7:4] == $past(st_r.pend))
      else $error("group flags read wrong");

   read_clear_a: assert property (statusRead ##0 !(|(grpEvent & st_r.arm))
      |=> (st_r.pend & $past(readdata[7:4])) == 4'h0)
      else $error("status read did not clear reported flags");

   set_wins_a: assert property (|(grpEvent & st_r.arm)
      |=> (st_r.pend & $past(grpEvent & st_r.arm)) == $past(grpEvent & st_r.arm))
      else $error("armed event lost");

   ac_read_a: assert property (stateRead |-> readdata[1] == $past(acDetectLevel))
      else $error("AC-detect level read wrong");

   state_zero_a: assert property (stateRead |->
      {readdata[31:6], readdata[3:2], readdata[0]} == 29'h0)
      else $error("unused state register bits not zero");

   // request only from an armed event
   irq_fall_a: assert property ($fell(irqN) |-> $past(|(grpEvent & st_r.arm)))
      else $error("interrupt raised without an armed event");

   // request released only by a read
   irq_rise_a: assert property ($rose(irqN) |->
      $past(accept && read && hitReg(address, IDX_IRQ_STATUS)))
      else $error("interrupt released without a status read");

endmodule

// ### verif/cis_tb.sv
// Purpose: Self-checking bench for the charger register bank
// Assumes: One wait cycle per bus request, waited for under a bound
// Notes:   Interrupt events are driven from a per-enable-bit loop
`timescale 1ns/100ps
module tb;
   import cis_pkg::*;
   logic        clock;
   logic        resetn;
   logic [9:0]  address;
   logic        read;
   logic        write;
   logic [3:0]  byteenable;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic        waitrequest;
   logic        totalTimeout;
   logic        precondTimeout;
   logic        temperatureValid;
   logic        inputValid;
   logic        endOfChargeFlag;
   logic [1:0]  chargingPhase;
   logic        acDetectLevel;
   logic        suspendCharging;
   logic [1:0]  totalTimeoutSelect;
   logic [1:0]  preconditionTimeoutSelect;
   logic [1:0]  inputOvervoltageSelect;
   logic        irqN;
   logic [31:0] d;
   logic [7:0]  cfgVals [4] = '{8'hB6, 8'h49, 8'hFF, 8'h00};
   int          n_errors;
   int          check_count;
   int          g;
   int          s;
   logic        act;

   cis_charger_regs #(.ADDR_W(10)) i_dut (
      .clock(clock), .resetn(resetn), .address(address), .read(read), .write(write),
      .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .totalTimeout(totalTimeout),
      .precondTimeout(precondTimeout), .temperatureValid(temperatureValid),
      .inputValid(inputValid), .endOfChargeFlag(endOfChargeFlag),
      .chargingPhase(chargingPhase), .acDetectLevel(acDetectLevel),
      .suspendCharging(suspendCharging), .totalTimeoutSelect(totalTimeoutSelect),
      .preconditionTimeoutSelect(preconditionTimeoutSelect),
      .inputOvervoltageSelect(inputOvervoltageSelect), .irqN(irqN));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Request held until waitrequest is sampled low, released after that edge
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd);
      int n;
      address   <= {idx, 2'b00};
      writedata <= {24'h00_0000, wd};
      read      <= ~wr;
      write     <= wr;
      for (n = 0; n < 50; n++) begin
         @(posedge clock);
         if (waitrequest === 1'b0) break;
      end
      rd = readdata;
      read  <= 1'b0;
      write <= 1'b0;
      @(posedge clock);
      if (n == 50) begin
         n_errors++;
         print_verdict();
      end
   endtask

   task automatic wreg(input logic [7:0] idx, input logic [7:0] v);
      logic [31:0] x;
      bus(1'b1, idx, v, x);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic setSig(input int sel, input logic v);
      case (sel)
         0: totalTimeout <= v;
         1: precondTimeout <= v;
         2: temperatureValid <= v;
         3: inputValid <= v;
         default: endOfChargeFlag <= v;
      endcase
   endtask

   function automatic logic [31:0] cfgOut();
      return {24'h00_0000, suspendCharging, 1'b0, totalTimeoutSelect,
              preconditionTimeoutSelect, inputOvervoltageSelect};
   endfunction

   initial begin
      n_errors = 0;
      check_count = 0;
      resetn <= 1'b0;
      read <= 1'b0;
      write <= 1'b0;
      address <= 10'h000;
      byteenable <= 4'hF;
      writedata <= 32'h0000_0000;
      {totalTimeout, precondTimeout, endOfChargeFlag} <= 3'h0;
      {temperatureValid, inputValid} <= 2'h3;
      chargingPhase <= 2'h0;
      acDetectLevel <= 1'b0;
      repeat (12) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      chk("irqN", {31'h0, irqN}, 32'h1);
      chk("cfg outputs", cfgOut(), {24'h0, RESET_CONFIG});
      bus(1'b0, IDX_IRQ_ENABLE, 8'h00, d);
      chk("enable", d, {24'h0, RESET_ENABLE});
      // config fields, bit 6 stored only
      foreach (cfgVals[i]) begin
         wreg(IDX_CONFIG, cfgVals[i]);
         chk("cfg outputs", cfgOut(), {24'h0, cfgVals[i] & 8'hBF});
         bus(1'b0, IDX_CONFIG, 8'h00, d);
         chk("config", d, {24'h0, cfgVals[i]});
      end
      wreg(IDX_CONFIG, 8'h5A);
      byteenable <= 4'hE;
      wreg(IDX_CONFIG, 8'h33);
      byteenable <= 4'hF;
      wreg(IDX_RESERVED_A, 8'hFF);
      wreg(8'h72, 8'hFF);
      bus(1'b0, IDX_CONFIG, 8'h00, d);
      chk("config kept", d, 32'h5A);
      bus(1'b0, IDX_RESERVED_A, 8'h00, d);
      chk("reserved", d, 32'h0);
      bus(1'b0, 8'h72, 8'h00, d);
      chk("unmapped", d, 32'h0);
      for (int i = 0; i < 16; i++) begin
         {inputValid, temperatureValid, precondTimeout, totalTimeout} <= 4'(i);
         endOfChargeFlag <= i[0] ^ i[1];
         chargingPhase <= i[3:2];
         acDetectLevel <= i[1];
         cyc(1);
         bus(1'b0, IDX_IRQ_STATUS, 8'h00, d);
         chk("status", d, {28'h0, i[0] | i[1], i[2], i[3], i[0] ^ i[1]});
         bus(1'b0, IDX_STATE, 8'h00, d);
         chk("state", d, {26'h0, i[3:2], 2'h0, i[1], 1'b0});
      end
      {totalTimeout, precondTimeout, temperatureValid, endOfChargeFlag} <= 4'h0;
      inputValid <= 1'b1;
      cyc(1);
      for (int b = 7; b >= 0; b--) begin
         g = b % 4;
         s = (g == 3) ? (b == 7 ? 0 : 1) : (g == 2 ? 2 : (g == 1 ? 3 : 4));
         // Timer events are expiry only, so both timer bits use a rising edge
         act = (b >= 4) || (g == 3);
         setSig(s, ~act);
         if (s != 3) inputValid <= 1'b1;
         cyc(2);
         wreg(IDX_IRQ_ENABLE, 8'h01 << b);
         wreg(IDX_IRQ_STATUS, 8'hF0 & ~(8'h10 << g));
         bus(1'b0, IDX_IRQ_STATUS, 8'h00, d);
         setSig(s, act);
         cyc(3);
         chk("irqN unarmed", {31'h0, irqN}, 32'h1);
         setSig(s, ~act);
         cyc(2);
         wreg(IDX_IRQ_STATUS, 8'hF0);
         setSig(s, act);
         cyc(3);
         chk("irqN event", {31'h0, irqN}, 32'h0);
         bus(1'b0, IDX_IRQ_STATUS, 8'h00, d);
         chk("group flag", {28'h0, d[7:4]}, 32'h1 << g);
         cyc(2);
         chk("irqN cleared", {31'h0, irqN}, 32'h1);
         bus(1'b0, IDX_IRQ_STATUS, 8'h00, d);
         chk("flag cleared", {28'h0, d[7:4]}, 32'h0);
      end
      // temperature event ignored without valid input
      temperatureValid <= 1'b0;
      inputValid <= 1'b0;
      wreg(IDX_IRQ_ENABLE, 8'h40);
      bus(1'b0, IDX_IRQ_STATUS, 8'h00, d);
      temperatureValid <= 1'b1;
      cyc(3);
      chk("irqN no input", {31'h0, irqN}, 32'h1);
      print_verdict();
   end
endmodule
